// File: verilog/lpm_regs.svh
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH
// command codes {cs_n, ras_n, cas_n, we_n}
`define LPM_CMD_NOP 4'h7
`define LPM_CMD_ACT 4'h3
`define LPM_CMD_READ 4'h5
`define LPM_CMD_WRITE 4'h4
`define LPM_CMD_BST 4'h6
`define LPM_CMD_PRE 4'h2
`define LPM_CMD_AREF 4'h1
`define LPM_CMD_LMR 4'h0
// standard mode register fields
`define LPM_MR_BL_LSB 0
`define LPM_MR_BT_BIT 3
`define LPM_MR_CL_LSB 4
`define LPM_MR_OP_LSB 7
`define LPM_MR_RESET 12'h032
// burst size encodings 1..4 = 2,4,8,16
`define LPM_BL_2 3'h1
`define LPM_BL_16 3'h4
`define LPM_CL_2 3'h2
`define LPM_CL_3 3'h3
// apb offsets
`define LPM_ADDR_MODE 8'h00
`define LPM_ADDR_STATE 8'h04
`define LPM_ADDR_BURST 8'h08
`define LPM_ADDR_CTRL 8'h0C
`endif

// File: verilog/lpm_pkg.sv
package lpm_pkg;
	typedef enum logic [2:0] {
		LPM_S_IDLE = 3'h0,
		LPM_S_ACTIVE = 3'h1,
		LPM_S_APD = 3'h3,
		LPM_S_PPD = 3'h2,
		LPM_S_REFRESH_SLEEP_ENTRY = 3'h6,
		LPM_S_DPD = 3'h7,
		LPM_S_UNINIT = 3'h5
	} lpm_state_t;
endpackage : lpm_pkg

// File: verilog/lpm_burst_addr.sv
`timescale 1ns/1ps
`include "lpm_regs.svh"
// column offset of beat idx in a burst; wraps inside the aligned block
module lpm_burst_addr (
	input wire logic [3:0] start,
	input wire logic [3:0] idx,
	input wire logic [2:0] bl_code,
	input wire logic interleaved,
	output logic [3:0] col
);
	logic [3:0] mask;
	logic [3:0] seq;
	always_comb begin
		unique case (bl_code)
			3'h1: mask = 4'h1;
			3'h2: mask = 4'h3;
			3'h3: mask = 4'h7;
			default: mask = 4'hF;
		endcase
		seq = 4'(start + idx);
		if (interleaved) begin
			col = (start & ~mask) | ((start ^ idx) & mask);
		end else begin
			col = (start & ~mask) | (seq & mask);
		end
	end
endmodule : lpm_burst_addr

// File: verilog/lpm_power_state.sv
// Notes on behaviour
// - cke sampled on each rising ck edge; low twice holds the low-power state
// - cke fall with nop: active or precharge power-down by bank state
// - cke fall with burst terminate, banks idle: deep power-down
// - cke fall with auto refresh, banks idle: self refresh
// - after full initialisation any valid command is accepted
// - load mode with both bank bits zero writes standard mode register
// - mode register kept until rewrite, deep power-down or power loss
// - mode reprogramming leaves array contents unchanged
// - burst size 2,4,8,16 for both types, reads and writes
// - upper column bits select aligned block; burst wraps in it
// - burst order from size, type and start column
// - read latency of 2 or 3 cycles to first data
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "lpm_regs.svh"
module lpm_power_state #(
	parameter int ROW_W = 13
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic CK,
	input wire logic CKE,
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [1:0] BA,
	input wire logic [ROW_W-1:0] ADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output lpm_pkg::lpm_state_t STATE,
	output logic READ_VALID,
	output logic WRITE_VALID,
	output logic [3:0] BURST_COL,
	output logic [11:0] MODE_REG
);
	import lpm_pkg::*;

	initial begin
		if (ROW_W < 12 || ROW_W > 16) begin
			$error("ROW_W out of range");
		end
	end

	typedef struct packed {
		logic [1:0] ck_sync;
		logic ck_prev;
		logic [1:0] cke_sync;
		logic [3:0][1:0] cmd_sync;
		logic cke_prev;
		lpm_state_t state;
		logic [11:0] mode;
		logic [3:0] bank_open;
		logic rd_act;
		logic wr_act;
		logic [3:0] beat;
		logic [3:0] start;
		logic [2:0] lat;
		logic [3:0] cmd_q;
		logic [1:0] ba_q;
		logic [ROW_W-1:0] addr_q;
		logic [1:0] aref_cnt;
		logic mr_done;
		logic emr_done;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [3:0] col;
		logic init_skip;
	} lpm_st_t;

	lpm_st_t s_q;
	lpm_st_t s_d;
	logic [3:0] col_w;
	logic [1:0] ba_w;

	lpm_burst_addr u_burst (
		.start(s_q.start),
		.idx(s_q.beat),
		.bl_code(s_q.mode[2:0]),
		.interleaved(s_q.mode[`LPM_MR_BT_BIT]),
		.col(col_w)
	);

	function automatic logic [3:0] burst_len(input logic [2:0] code);
		burst_len = 4'((5'h01 << code) - 5'h01);
	endfunction : burst_len

	logic ck_rise;
	logic cke_n;
	logic [3:0] cmd_n;
	logic apb_acc;
	assign ck_rise = s_q.ck_sync[1] & ~s_q.ck_prev;
	assign cke_n = s_q.cke_sync[1];
	assign cmd_n = {s_q.cmd_sync[3][1], s_q.cmd_sync[2][1], s_q.cmd_sync[1][1],
		s_q.cmd_sync[0][1]};
	assign apb_acc = PSEL & PENABLE & ~s_q.pready;

	always_comb begin
		s_d = s_q;
		ba_w = 2'h0;
		s_d.ck_sync = {s_q.ck_sync[0], CK};
		s_d.ck_prev = s_q.ck_sync[1];
		s_d.cke_sync = {s_q.cke_sync[0], CKE};
		s_d.cmd_sync[3] = {s_q.cmd_sync[3][0], CS_N};
		s_d.cmd_sync[2] = {s_q.cmd_sync[2][0], RAS_N};
		s_d.cmd_sync[1] = {s_q.cmd_sync[1][0], CAS_N};
		s_d.cmd_sync[0] = {s_q.cmd_sync[0][0], WE_N};
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.col = col_w;
		if (ck_rise) begin
			s_d.cke_prev = cke_n;
			s_d.cmd_q = cmd_n[3] ? `LPM_CMD_NOP : cmd_n;
			unique case ({s_q.cke_prev, cke_n})
				2'b00: begin
					s_d.state = s_q.state;
				end
				2'b01: begin
					if (s_q.state == LPM_S_DPD) begin
						s_d.state = LPM_S_UNINIT;
						s_d.mode = `LPM_MR_RESET;
						s_d.aref_cnt = 2'h0;
						s_d.mr_done = 1'b0;
						s_d.emr_done = 1'b0;
					end else if (s_q.state == LPM_S_APD) begin
						s_d.state = LPM_S_ACTIVE;
					end else if (s_q.state == LPM_S_PPD || s_q.state == LPM_S_REFRESH_SLEEP_ENTRY) begin
						s_d.state = LPM_S_IDLE;
					end
				end
				2'b10: begin
					if (s_q.state == LPM_S_UNINIT) begin
						s_d.state = LPM_S_UNINIT;
					end else if (|s_q.bank_open) begin
						s_d.state = LPM_S_APD;
					end else if (cmd_n == `LPM_CMD_BST) begin
						s_d.state = LPM_S_DPD;
					end else if (cmd_n == `LPM_CMD_AREF) begin
						s_d.state = LPM_S_REFRESH_SLEEP_ENTRY;
					end else begin
						s_d.state = LPM_S_PPD;
					end
					s_d.rd_act = 1'b0;
					s_d.wr_act = 1'b0;
				end
				default: begin
					ba_w = BA;
					s_d.ba_q = ba_w;
					s_d.addr_q = ADDR;
					if (s_q.rd_act || s_q.wr_act) begin
						if (s_q.lat > 3'h0) begin
							s_d.lat = 3'(s_q.lat - 3'h1);
						end else if (s_q.beat == burst_len(s_q.mode[2:0])) begin
							s_d.rd_act = 1'b0;
							s_d.wr_act = 1'b0;
						end else begin
							s_d.beat = 4'(s_q.beat + 4'h1);
						end
					end
					unique case (cmd_n[3] ? `LPM_CMD_NOP : cmd_n)
						`LPM_CMD_ACT: s_d.bank_open[BA] = 1'b1;
						`LPM_CMD_PRE: begin
							if (ADDR[10]) begin
								s_d.bank_open = 4'h0;
							end else begin
								s_d.bank_open[BA] = 1'b0;
							end
						end
						`LPM_CMD_AREF: begin
							if (s_q.aref_cnt != 2'h2) begin
								s_d.aref_cnt = 2'(s_q.aref_cnt + 2'h1);
							end
						end
						`LPM_CMD_LMR: begin
							if (BA == 2'h0) begin
								s_d.mode = ADDR[11:0];
								s_d.mr_done = 1'b1;
							end else if (BA == 2'h2) begin
								s_d.emr_done = 1'b1;
							end
						end
						`LPM_CMD_READ, `LPM_CMD_WRITE: begin
							s_d.rd_act = cmd_n == `LPM_CMD_READ;
							s_d.wr_act = cmd_n == `LPM_CMD_WRITE;
							s_d.beat = 4'h0;
							s_d.start = ADDR[3:0];
							s_d.lat = (cmd_n == `LPM_CMD_READ) ?
								3'(s_q.mode[6:4] - 3'h1) : 3'h0;
						end
						`LPM_CMD_BST: s_d.rd_act = 1'b0;
						default: ;
					endcase
					if (s_q.state == LPM_S_UNINIT) begin
						if ((s_q.aref_cnt == 2'h2 && s_q.mr_done && s_q.emr_done) ||
							s_q.init_skip) begin
							s_d.state = LPM_S_IDLE;
						end
					end else begin
						s_d.state = (|s_d.bank_open) ? LPM_S_ACTIVE : LPM_S_IDLE;
					end
				end
			endcase
		end
		if (apb_acc) begin
			s_d.pready = 1'b1;
			unique case (PADDR)
				`LPM_ADDR_MODE: s_d.prdata = {20'h00000, s_q.mode};
				`LPM_ADDR_STATE: s_d.prdata = {21'h000000, s_q.aref_cnt, s_q.emr_done,
					s_q.mr_done, s_q.bank_open, s_q.state};
				`LPM_ADDR_BURST: s_d.prdata = {26'h0000000, s_q.wr_act, s_q.rd_act,
					s_q.beat};
				`LPM_ADDR_CTRL: begin
					s_d.prdata = {31'h00000000, s_q.init_skip};
					if (PWRITE) begin
						s_d.init_skip = PWDATA[0];
					end
				end
				default: begin
					s_d.prdata = 32'h00000000;
					s_d.pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.state <= LPM_S_UNINIT;
			s_q.mode <= `LPM_MR_RESET;
			s_q.cmd_q <= `LPM_CMD_NOP;
			s_q.cmd_sync <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign PRDATA = s_q.prdata;
	assign PREADY = s_q.pready;
	assign PSLVERR = s_q.pslverr;
	assign STATE = s_q.state;
	// no array side effects on mode writes
	assign READ_VALID = s_q.rd_act & (s_q.lat == 3'h0);
	assign WRITE_VALID = s_q.wr_act;
	assign BURST_COL = s_q.col;
	assign MODE_REG = s_q.mode;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	sequence fall_edge_s;
		ck_rise && s_q.cke_prev && !cke_n;
	endsequence

	hold_low_power_a: assert property (
		ck_rise && !s_q.cke_prev && !cke_n |=> STATE == $past(STATE))
		else $error("low-power state changed with cke low");
	apd_entry_a: assert property (
		fall_edge_s and (|s_q.bank_open) && s_q.state != LPM_S_UNINIT
		|=> STATE == LPM_S_APD)
		else $error("active power-down not entered");
	dpd_entry_a: assert property (
		fall_edge_s and s_q.bank_open == 4'h0 && cmd_n == `LPM_CMD_BST &&
		s_q.state != LPM_S_UNINIT |=> STATE == LPM_S_DPD)
		else $error("deep power-down not entered");
	refresh_sleep_entry_entry_a: assert property (
		fall_edge_s and s_q.bank_open == 4'h0 && cmd_n == `LPM_CMD_AREF &&
		s_q.state != LPM_S_UNINIT |=> STATE == LPM_S_REFRESH_SLEEP_ENTRY)
		else $error("self refresh not entered");
	mode_write_a: assert property (
		ck_rise && s_q.cke_prev && cke_n && cmd_n == `LPM_CMD_LMR && BA == 2'h0
		|=> MODE_REG == $past(ADDR[11:0]))
		else $error("mode register not written");
	mode_keep_a: assert property (
		$changed(MODE_REG) |-> $past(ck_rise) && ($past(STATE) == LPM_S_DPD ||
		$past(cmd_n) == `LPM_CMD_LMR))
		else $error("mode register changed without cause");
	init_done_a: assert property (
		STATE == LPM_S_UNINIT ##1 STATE == LPM_S_IDLE |-> $past(s_q.init_skip) ||
		($past(s_q.aref_cnt) == 2'h2 && $past(s_q.mr_done) && $past(s_q.emr_done)))
		else $error("left init early");
	burst_col_a: assert property (
		READ_VALID || WRITE_VALID |=> (BURST_COL | 4'(burst_len(MODE_REG[2:0]))) ==
		($past(s_q.start) | 4'(burst_len(MODE_REG[2:0]))))
		else $error("burst left its block");
endmodule : lpm_power_state

// File: testbench/lpm_ctrl_model.sv
`timescale 1ns/1ps
`include "lpm_regs.svh"
module lpm_ctrl_model #(
	parameter int ROW_W = 13,
	parameter int STARTUP_CK = 4,
	parameter int WAIT_CK = 2
) (
	input wire logic clock,
	output logic ck,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] ba,
	output logic [ROW_W-1:0] addr
);
	initial begin
		ck = 1'b0;
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = `LPM_CMD_NOP;
		ba = 2'h0;
		addr = '0;
	end
	// one legal command
	// ck stands still between commands, so a stalled caller adds no edges
	task automatic cmd(input logic k, input logic [3:0] op, input logic [1:0] b,
		input logic [ROW_W-1:0] a);
		@(posedge clock);
		cke <= k;
		{cs_n, ras_n, cas_n, we_n} <= op;
		ba <= b;
		addr <= a;
		repeat (7) @(posedge clock);
		ck <= 1'b1;
		repeat (8) @(posedge clock);
		ck <= 1'b0;
		ba <= ~b;
		addr <= ~a;
	endtask : cmd
	task automatic nops(input int n);
		repeat (n) cmd(1'b1, `LPM_CMD_NOP, 2'h0, '0);
	endtask : nops
	// full init
	// startup wait is scaled down; only legal mode values are passed in
	task automatic init(input logic [11:0] mode);
		nops(STARTUP_CK);
		cmd(1'b1, `LPM_CMD_PRE, 2'h0, ROW_W'(12'h400));
		nops(WAIT_CK);
		repeat (2) begin
			cmd(1'b1, `LPM_CMD_AREF, 2'h0, '0);
			nops(WAIT_CK);
		end
		cmd(1'b1, `LPM_CMD_LMR, 2'h0, ROW_W'(mode));
		nops(WAIT_CK);
		cmd(1'b1, `LPM_CMD_LMR, 2'h2, '0);
		nops(WAIT_CK);
	endtask : init
endmodule : lpm_ctrl_model

// File: testbench/lpm_power_state_tb_top.sv
`timescale 1ns/1ps
`include "lpm_regs.svh"
module lpm_power_state_tb_top;
	import lpm_pkg::*;
	localparam int LIMIT = 20000;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic saw_rd = 1'b0;
	logic saw_wr = 1'b0;
	logic ck, cke, cs_n, ras_n, cas_n, we_n, pready, pslverr, rd_valid, wr_valid, err;
	logic [1:0] ba;
	logic [12:0] addr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic [3:0] bcol;
	logic [11:0] mode_reg;
	lpm_state_t state;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #2.5 clock = ~clock;
	lpm_power_state u_lpm_power_state (.CLOCK(clock), .RST_N(rst_n), .CK(ck), .CKE(cke),
		.CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STATE(state),
		.READ_VALID(rd_valid), .WRITE_VALID(wr_valid), .BURST_COL(bcol), .MODE_REG(mode_reg));
	lpm_ctrl_model u_lpm_ctrl_model (.clock(clock), .ck(ck), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
	// burst beats are short levels; latch them so a check between commands cannot miss one
	always @(posedge clock) begin
		saw_rd <= saw_rd | (rd_valid === 1'b1);
		saw_wr <= saw_wr | (wr_valid === 1'b1);
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic step(input logic k, input logic [3:0] op, input lpm_state_t e);
		u_lpm_ctrl_model.cmd(k, op, 2'h0, 13'h0400);
		chk("state", {29'h0, state}, {29'h0, e});
	endtask : step
	task automatic t_reset();
		chk("state", {29'h0, state}, {29'h0, LPM_S_UNINIT});
		apb(1'b0, `LPM_ADDR_MODE, 32'h0);
		chk("mode_rd", rd, 32'h032);
		apb(1'b1, `LPM_ADDR_MODE, 32'h5A5);
		apb(1'b0, `LPM_ADDR_MODE, 32'h0);
		chk("mode_ro", rd, 32'h032);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", {rd[30:0], err}, 32'h1);
		step(1'b0, `LPM_CMD_NOP, LPM_S_UNINIT);
		step(1'b1, `LPM_CMD_NOP, LPM_S_UNINIT);
	endtask : t_reset
	task automatic t_init();
		u_lpm_ctrl_model.init(12'h033);
		chk("state", {29'h0, state}, {29'h0, LPM_S_IDLE});
		chk("mode", {20'h0, mode_reg}, 32'h033);
	endtask : t_init
	task automatic t_idle_sleep();
		step(1'b0, `LPM_CMD_NOP, LPM_S_PPD);
		step(1'b0, `LPM_CMD_AREF, LPM_S_PPD);
		step(1'b1, `LPM_CMD_NOP, LPM_S_IDLE);
		u_lpm_ctrl_model.nops(2);
		step(1'b0, `LPM_CMD_AREF, LPM_S_REFRESH_SLEEP_ENTRY);
		step(1'b0, `LPM_CMD_NOP, LPM_S_REFRESH_SLEEP_ENTRY);
		step(1'b1, `LPM_CMD_NOP, LPM_S_IDLE);
		u_lpm_ctrl_model.nops(2);
	endtask : t_idle_sleep
	task automatic t_bank();
		step(1'b1, `LPM_CMD_ACT, LPM_S_ACTIVE);
		u_lpm_ctrl_model.cmd(1'b1, `LPM_CMD_READ, 2'h0, 13'h0005);
		u_lpm_ctrl_model.nops(6);
		chk("read_valid", {31'h0, saw_rd}, 32'h1);
		u_lpm_ctrl_model.cmd(1'b1, `LPM_CMD_WRITE, 2'h0, 13'h0002);
		u_lpm_ctrl_model.nops(6);
		chk("write_valid", {31'h0, saw_wr}, 32'h1);
		step(1'b0, `LPM_CMD_NOP, LPM_S_APD);
		step(1'b0, `LPM_CMD_BST, LPM_S_APD);
		step(1'b1, `LPM_CMD_NOP, LPM_S_ACTIVE);
		u_lpm_ctrl_model.nops(2);
		step(1'b1, `LPM_CMD_PRE, LPM_S_IDLE);
		u_lpm_ctrl_model.nops(2);
	endtask : t_bank
	task automatic t_mode();
		for (int b = 2; b >= 0; b -= 2) begin
			u_lpm_ctrl_model.cmd(1'b1, `LPM_CMD_LMR, 2'(b), 13'h003C);
			u_lpm_ctrl_model.nops(2);
			chk("mode", {20'h0, mode_reg}, (b == 0) ? 32'h03C : 32'h033);
		end
	endtask : t_mode
	task automatic t_deep();
		step(1'b0, `LPM_CMD_BST, LPM_S_DPD);
		step(1'b0, `LPM_CMD_NOP, LPM_S_DPD);
		step(1'b1, `LPM_CMD_NOP, LPM_S_UNINIT);
		chk("mode", {20'h0, mode_reg}, 32'h032);
		apb(1'b1, `LPM_ADDR_CTRL, 32'h1);
		apb(1'b0, `LPM_ADDR_CTRL, 32'h0);
		chk("ctrl", rd, 32'h1);
		step(1'b1, `LPM_CMD_NOP, LPM_S_IDLE);
	endtask : t_deep
	// read latency 2: first beat shows after one nop, then one beat per command
	task automatic t_burst(input logic [2:0] c, input logic t, input logic [3:0] s);
		logic [3:0] m, e;
		u_lpm_ctrl_model.cmd(1'b1, `LPM_CMD_LMR, 2'h0, 13'({5'h00, `LPM_CL_2, t, c}));
		u_lpm_ctrl_model.nops(2);
		u_lpm_ctrl_model.cmd(1'b1, `LPM_CMD_READ, 2'h0, 13'(s));
		u_lpm_ctrl_model.nops(1);
		m = 4'((5'h01 << c) - 5'h01);
		for (int i = 0; i <= int'(m); i++) begin
			e = t ? (s ^ 4'(i)) : 4'(s + 4'(i));
			e = (s & ~m) | (e & m);
			chk("burst_col", {28'h0, bcol}, {28'h0, e});
			u_lpm_ctrl_model.nops(1);
		end
	endtask : t_burst
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		t_reset();
		t_init();
		t_idle_sleep();
		t_bank();
		t_mode();
		t_deep();
		t_burst(3'h1, 1'b1, 4'h3);
		t_burst(3'h2, 1'b0, 4'h5);
		t_burst(3'h3, 1'b1, 4'hB);
		t_burst(3'h4, 1'b0, 4'hE);
		give_verdict();
	end
endmodule : lpm_power_state_tb_top
